//--- bench/low_pf_stage_bench.sv
// Purpose: Self-checking bench for the low power factor stage
// Assumes: Ten cycle tick; waits carry margin for sample phase
// Notes: Trip and alarm paths tested apart, their priority is open
`timescale 1ns/1ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module low_pf_stage_bench;
  import low_pf_pkg::*;
  localparam int TC = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [PF_W-1:0] pfReq = 7'h64;
  logic blockReq = 1'b0;
  logic [PF_W-1:0] pfLine;
  logic blockLine;
  logic alarmModeEn = 1'b0;
  logic [PF_W-1:0] tripThreshold = TRIP_DEFAULT;
  logic [PF_W-1:0] alarmThreshold = ALARM_DEFAULT;
  logic [TIME_W-1:0] tripDelay = 19'h00003;
  logic [TIME_W-1:0] alarmDelay = 19'h00004;
  logic [GRP_W-1:0] settingGroup = 3'h0;
  logic forceEnable = 1'b0;
  stage_status_t forceStatus = ST_NORMAL;
  logic [NUM_EVENTS-1:0] onMask = 5'h1F;
  logic [NUM_EVENTS-1:0] offMask = 5'h1F;
  logic counterClear = 1'b0;
  logic [31:0] timeStamp = 32'h0;
  logic [REC_IDX_W-1:0] recReadIdx = 4'h0;
  stage_status_t status;
  logic [NUM_EVENTS-1:0] eventOn, eventOff, seenOn, seenOff;
  logic [31:0] eventTime;
  logic [CNT_W-1:0] cntAlarmStart, cntAlarm, cntStart, cntTrip, cntBlocked;
  logic [TIME_W-1:0] alarmRemaining, alarmExpected, tripRemaining;
  logic [15:0] ratioToTrip;
  logic [77:0] recData;
  logic [31:0] evStamp = 32'h0;
  logic clrSeen = 1'b1;
  int fails = 0;
  int check_count = 0;
  int expStart = 0;
  int expTrip = 0;
  logic [GRP_W-1:0] recGroups[$];
  logic [PF_W-1:0] recPfs[$];
  event_id_t recEvents[$];
  logic [31:0] seed = 32'd81784;

  always #12.5 clock = ~clock;
  always @(posedge clock) timeStamp <= timeStamp + 32'h1;
  // Event pulses last one cycle, so collect them
  always @(posedge clock) begin
    seenOn <= clrSeen ? '0 : seenOn | eventOn;
    seenOff <= clrSeen ? '0 : seenOff | eventOff;
    // Stamp of the edge that launched the pulse seen now
    if ((eventOn | eventOff) != '0) evStamp <= timeStamp - 32'h1;
  end

  pf_source_model #(.PERIOD(TC)) pf_source_model_inst (.clock(clock), .pfReq(pfReq),
    .blockReq(blockReq), .pfOut(pfLine), .blockOut(blockLine));

  low_pf_stage #(.TICK_CYC(TC)) low_pf_stage_inst (.clock(clock), .rst(rst),
    .threePhasePowerFactor(pfLine), .blockRaw(blockLine), .alarmModeEn(alarmModeEn),
    .tripThreshold(tripThreshold), .alarmThreshold(alarmThreshold), .tripDelay(tripDelay),
    .alarmDelay(alarmDelay), .settingGroup(settingGroup), .forceEnable(forceEnable),
    .forceStatus(forceStatus), .onMask(onMask), .offMask(offMask),
    .counterClear(counterClear), .timeStamp(timeStamp), .recReadIdx(recReadIdx),
    .status(status), .eventOn(eventOn), .eventOff(eventOff), .eventTime(eventTime),
    .cntAlarmStart(cntAlarmStart), .cntAlarm(cntAlarm), .cntStart(cntStart),
    .cntTrip(cntTrip), .cntBlocked(cntBlocked), .alarmRemaining(alarmRemaining),
    .alarmExpected(alarmExpected), .tripRemaining(tripRemaining),
    .ratioToTrip(ratioToTrip), .recData(recData));

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference pick-up: below threshold to pick, 103 percent to let go
  function automatic bit picked(int pf, int thr, bit held);
    return held ? (pf * RATIO_SCALE < thr * RESET_RATIO_PCT) : (pf < thr);
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    int pf;
    step(4);
    rst = 1'b0;
    clrSeen = 1'b0;
    `CHK("status", ST_NORMAL, status)
    `CHK("counters", 32'h0, {cntStart, cntTrip})
    $display("Done reset");
    for (int i = 0; i < 2; i++) begin
      pf = 5 + int'(next_rand() % 32'd70);
      settingGroup = 3'(next_rand());
      clrSeen = 1'b1;
      pfReq = 7'(pf);
      step(1);
      clrSeen = 1'b0;
      step(29);
      `CHK("start", picked(pf, 80, 0) ? ST_START : ST_NORMAL, status)
      `CHK("ratio", 16'(pf * RATIO_SCALE / 80), ratioToTrip)
      step(35);
      `CHK("trip", ST_TRIP, status)
      `CHK("trip time done", 19'h0, tripRemaining)
      `CHK("event time", evStamp, eventTime)
      expStart++;
      expTrip++;
      recGroups.push_back(settingGroup);
      recGroups.push_back(settingGroup);
      recPfs.push_back(7'(pf));
      recPfs.push_back(7'(pf));
      recEvents.push_back(EV_START);
      recEvents.push_back(EV_TRIP);
      `CHK("on events", 5'h06, seenOn)
      `CHK("counts", {16'(expStart), 16'(expTrip)}, {cntStart, cntTrip})
      pfReq = 7'h52;
      step(60);
      `CHK("held at 82", picked(82, 80, 1) ? ST_TRIP : ST_NORMAL, status)
      pfReq = 7'h53;
      step(60);
      `CHK("release at 83", picked(83, 80, 1) ? ST_TRIP : ST_NORMAL, status)
      `CHK("off events", 5'h06, seenOff)
      pfReq = 7'h64;
    end
    $display("Done trip");
    blockReq = 1'b1;
    step(TC);
    pfReq = 7'h28;
    step(80);
    `CHK("blocked", ST_BLOCKED, status)
    `CHK("no trip", 16'(expTrip), cntTrip)
    `CHK("blocked count", 16'h1, cntBlocked)
    recGroups.push_back(settingGroup);
    recPfs.push_back(7'h28);
    recEvents.push_back(EV_BLOCK);
    pfReq = 7'h64;
    step(40);
    blockReq = 1'b0;
    step(TC);
    foreach (recGroups[k]) begin
      recReadIdx = 4'(k);
      step(2);
      `CHK("record group", recGroups[k], recData[GRP_W-1:0])
      `CHK("record pf", recPfs[k], recData[TIME_W+GRP_W+PF_W +: PF_W])
      `CHK("record event", recEvents[k], recData[TIME_W+GRP_W+3*PF_W +: 3])
    end
    recReadIdx = 4'hC;
    step(2);
    `CHK("empty slot", 78'h0, recData)
    $display("Done block and records");
    tripDelay = 19'h00008;
    pfReq = 7'h28;
    step(30);
    `CHK("start before block", ST_START, status)
    `CHK("trip time left", 1'b1, tripRemaining >= 19'h1 && tripRemaining <= tripDelay)
    // Block lands several ticks before the delay runs out
    blockReq = 1'b1;
    step(100);
    `CHK("start cleared", 1'b0, status == ST_START)
    `CHK("trip held off", 16'(expTrip), cntTrip)
    pfReq = 7'h64;
    step(40);
    blockReq = 1'b0;
    tripDelay = 19'h00003;
    step(TC);
    $display("Done block in start");
    alarmModeEn = 1'b1;
    onMask = 5'h00;
    clrSeen = 1'b1;
    pfReq = 7'h55;
    step(1);
    clrSeen = 1'b0;
    step(29);
    `CHK("alarm start", ST_ALARM_START, status)
    `CHK("alarm expected", alarmDelay, alarmExpected)
    `CHK("alarm time left", 1'b1, alarmRemaining >= 19'h1 && alarmRemaining <= alarmDelay)
    step(40);
    `CHK("alarm", ST_ALARM, status)
    `CHK("alarm time done", 19'h0, alarmRemaining)
    `CHK("alarm counts", 32'h00010001, {cntAlarmStart, cntAlarm})
    `CHK("masked on events", 5'h00, seenOn)
    pfReq = 7'h64;
    step(60);
    `CHK("alarm off events", 5'h18, seenOff)
    alarmModeEn = 1'b0;
    onMask = 5'h1F;
    pfReq = 7'h55;
    step(70);
    `CHK("trips only", ST_NORMAL, status)
    tripThreshold = 7'h5A;
    step(30);
    `CHK("new group threshold", ST_START, status)
    pfReq = 7'h64;
    tripThreshold = TRIP_DEFAULT;
    step(60);
    $display("Done alarm and mode");
    forceEnable = 1'b1;
    for (int s = 0; s < 6; s++) begin
      forceStatus = stage_status_t'(s);
      step(15);
      `CHK("forced", stage_status_t'(s), status)
    end
    settingGroup = 3'h5;
    step(15);
    `CHK("force kept over group", ST_ALARM, status)
    forceEnable = 1'b0;
    step(20);
    counterClear = 1'b1;
    step(1);
    counterClear = 1'b0;
    step(4);
    `CHK("cleared", 80'h0, {cntAlarmStart, cntAlarm, cntStart, cntTrip, cntBlocked})
    $display("Done force and clear");
    wrap_up();
  end

  // Whole run needs about 1130 cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule

//--- bench/pf_source_model.sv
// Purpose: Measurement chain and blocking matrix stand-in
// Assumes: Bench asks for a power factor level and a block level
// Notes: Sample only moves on the chain's own time base
`timescale 1ns/1ps
module pf_source_model #(
  parameter int PERIOD = 10
) (
  input wire logic clock,
  input wire logic [6:0] pfReq,
  input wire logic blockReq,
  output logic [6:0] pfOut,
  output logic blockOut
);
  int phase = 0;
  initial pfOut = 7'h64;
  // Refresh once per period, so the stage never sees mid-tick changes
  always @(posedge clock) begin
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    if (phase == 0) begin
      pfOut <= pfReq;
    end
  end
  // Blocking matrix is plain logic
  assign blockOut = blockReq;
endmodule

//--- rtl/definite_time_path.sv
// Purpose: One pick-up path with blocking and definite-time delay
// Assumes: tick is a one-cycle 5 ms enable
// Notes: Used twice, for trip and for alarm
`timescale 1ns/1ps
module definite_time_path #(
  parameter int TW = low_pf_pkg::TIME_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic pickup,
  input wire logic blockIn,
  input wire logic [TW-1:0] delayTicks,
  output logic startOut,
  output logic operateOut,
  output logic blockedOut,
  output logic [TW-1:0] remaining
);
  import low_pf_pkg::*;
  dt_state_t state_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= DT_IDLE;
      remaining <= '0;
    end else if (tick) begin
      case (state_reg)
        DT_IDLE: begin
          if (enable && pickup && blockIn) begin
            state_reg <= DT_BLOCKED;
          end else if (enable && pickup) begin
            state_reg <= DT_RUN;
            remaining <= delayTicks;
          end
        end
        DT_RUN: begin
          if (!enable || !pickup || blockIn) begin
            state_reg <= DT_IDLE;
            remaining <= '0;
          end else if (remaining <= TW'(1)) begin
            state_reg <= DT_OPERATE;
            remaining <= '0;
          end else begin
            remaining <= remaining - TW'(1);
          end
        end
        DT_OPERATE: begin
          if (!enable || !pickup || blockIn) state_reg <= DT_IDLE;
        end
        DT_BLOCKED: begin
          if (!enable || !pickup || !blockIn) state_reg <= DT_IDLE;
        end
        default: state_reg <= DT_IDLE;
      endcase
    end
  end
  assign startOut = (state_reg == DT_RUN) || (state_reg == DT_OPERATE);
  assign operateOut = (state_reg == DT_OPERATE);
  assign blockedOut = (state_reg == DT_BLOCKED);

  property p_operate_needs_start;
    @(posedge clock) disable iff (rst) $rose(operateOut) |-> $past(startOut);
  endproperty
  a_operate_needs_start: assert property (p_operate_needs_start)
    else $error("Operate without preceding start");
  property p_block_no_operate;
    @(posedge clock) disable iff (rst) blockedOut |-> !operateOut;
  endproperty
  a_block_no_operate: assert property (p_block_no_operate)
    else $error("Operate while blocked");
endmodule

//--- rtl/low_pf_pkg.sv
// Purpose: Shared constants and types for the low power factor stage
// Assumes: Power factor in hundredths, 0..100; time in 5 ms ticks
// Notes: Clock 40 MHz
package low_pf_pkg;
  localparam int CLOCK_HZ = 40000000;
  localparam int TICK_US = 5000;
  localparam int TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_US;
  localparam int PF_W = 7;
  localparam int TIME_W = 19;
  localparam int GRP_W = 3;
  localparam int CNT_W = 16;
  localparam int REC_DEPTH = 12;
  localparam int REC_IDX_W = 4;
  localparam int HIST_DEPTH = 41;
  localparam int PRE_TRIG_TICKS = 4;
  localparam int PRE_FAULT_TICKS = 40;
  localparam logic [PF_W-1:0] TRIP_DEFAULT = 7'h50;
  localparam logic [PF_W-1:0] ALARM_DEFAULT = 7'h5A;
  localparam logic [PF_W-1:0] PF_MIN = 7'h05;
  localparam logic [PF_W-1:0] PF_MAX = 7'h63;
  localparam int RESET_RATIO_PCT = 103;
  localparam int RATIO_SCALE = 100;
  typedef enum logic [2:0] {
    ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED, ST_ALARM_START, ST_ALARM
  } stage_status_t;
  typedef enum logic [2:0] {
    EV_BLOCK, EV_START, EV_TRIP, EV_ALARM_START, EV_ALARM
  } event_id_t;
  localparam int NUM_EVENTS = 5;
  typedef enum logic [1:0] {
    DT_IDLE, DT_RUN, DT_OPERATE, DT_BLOCKED
  } dt_state_t;
endpackage

//--- rtl/low_pf_stage.sv
// Purpose: Low power factor protection stage with trip and alarm paths
// Assumes: Sample valid pulses every 5 ms; settings held by caller
// Notes: All outputs registered; rules follow
// Contract
// - Input is three-phase power factor, refreshed every 5 ms.
// - Acts when power factor falls below threshold, leading or lagging.
// - Trip threshold 0.05..0.99 in 0.01 steps, default 0.8.
// - Alarm threshold default 0.9, only active in trips-with-alarms mode.
// - Mode selects trips only or trips with alarms, default with alarms.
// - Release at 103 percent of the threshold.
// - Thresholds come from active setting group, changeable while running.
// - General settings including forcing are static, group independent.
// - Forcing sets status to any state when forcing is enabled.
// - Blocking sampled at start of each processing cycle.
// - Unblocked pick-up asserts start and begins delay.
// - Blocked pick-up asserts blocked, no timing or trip.
// - Blocking during start clears start as on release.
// - Trip and alarm use definite-time delays.
// - Pulses ON and OFF events per mask, with time stamp.
// - Resettable counters for alarm start, alarm, start, trip, blocked.
// - Keeps last twelve fault records on start, trip, blocked ON.
// - Record holds event, PF -20 ms, PF now, PF -200 ms, time left, group.
// - Shows remaining alarm time in 5 ms units and expected delay.
// - Shows measured over trip threshold ratio in 0.01 units.
`timescale 1ns/1ps
module low_pf_stage
  import low_pf_pkg::*;
#(
  parameter int TICK_CYC = low_pf_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [low_pf_pkg::PF_W-1:0] threePhasePowerFactor,
  input wire logic blockRaw,
  input wire logic alarmModeEn,
  input wire logic [low_pf_pkg::PF_W-1:0] tripThreshold,
  input wire logic [low_pf_pkg::PF_W-1:0] alarmThreshold,
  input wire logic [low_pf_pkg::TIME_W-1:0] tripDelay,
  input wire logic [low_pf_pkg::TIME_W-1:0] alarmDelay,
  input wire logic [low_pf_pkg::GRP_W-1:0] settingGroup,
  input wire logic forceEnable,
  input wire low_pf_pkg::stage_status_t forceStatus,
  input wire logic [low_pf_pkg::NUM_EVENTS-1:0] onMask,
  input wire logic [low_pf_pkg::NUM_EVENTS-1:0] offMask,
  input wire logic counterClear,
  input wire logic [31:0] timeStamp,
  input wire logic [low_pf_pkg::REC_IDX_W-1:0] recReadIdx,
  output low_pf_pkg::stage_status_t status,
  output logic [low_pf_pkg::NUM_EVENTS-1:0] eventOn,
  output logic [low_pf_pkg::NUM_EVENTS-1:0] eventOff,
  output logic [31:0] eventTime,
  output logic [low_pf_pkg::CNT_W-1:0] cntAlarmStart,
  output logic [low_pf_pkg::CNT_W-1:0] cntAlarm,
  output logic [low_pf_pkg::CNT_W-1:0] cntStart,
  output logic [low_pf_pkg::CNT_W-1:0] cntTrip,
  output logic [low_pf_pkg::CNT_W-1:0] cntBlocked,
  output logic [low_pf_pkg::TIME_W-1:0] alarmRemaining,
  output logic [low_pf_pkg::TIME_W-1:0] alarmExpected,
  output logic [low_pf_pkg::TIME_W-1:0] tripRemaining,
  output logic [15:0] ratioToTrip,
  output logic [77:0] recData
);
  // Record: time 32, event 3, pf-20 7, pf 7, pf-200 7, remaining 19, group 3
  localparam int REC_W = 78;
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC too small");
  end

  // Time base divider
  logic [31:0] divCnt_reg;
  logic tick;
  always_ff @(posedge clock) begin
    if (rst || divCnt_reg == 32'(TICK_CYC - 1)) divCnt_reg <= '0;
    else divCnt_reg <= divCnt_reg + 32'h1;
  end
  assign tick = (divCnt_reg == 32'(TICK_CYC - 1));

  // Blocking pin through two flip-flops, then latched per cycle
  logic blkSync1_reg, blkSync2_reg, blkSample_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      blkSync1_reg <= 1'b0;
      blkSync2_reg <= 1'b0;
      blkSample_reg <= 1'b0;
    end else begin
      blkSync1_reg <= blockRaw;
      blkSync2_reg <= blkSync1_reg;
      if (tick) blkSample_reg <= blkSync2_reg;
    end
  end

  // Power factor sampled once per cycle, history for pre-trigger values
  logic [PF_W-1:0] pfNow_reg;
  logic [PF_W-1:0] hist_reg [HIST_DEPTH];
  logic hTick_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      pfNow_reg <= '0;
      hTick_reg <= 1'b0;
    end else begin
      hTick_reg <= tick;
      if (tick) pfNow_reg <= threePhasePowerFactor;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_hist
      // Entry n holds the sample taken n ticks back
      if (gi == 0) begin : g_head
        always_ff @(posedge clock) begin
          if (rst) hist_reg[gi] <= '0;
          else if (hTick_reg) hist_reg[gi] <= pfNow_reg;
        end
      end else begin : g_tail
        always_ff @(posedge clock) begin
          if (rst) hist_reg[gi] <= '0;
          else if (hTick_reg) hist_reg[gi] <= hist_reg[gi-1];
        end
      end
    end
  endgenerate

  // Pick-up with 103 percent release; magnitude makes lead or lag equal
  logic tripPick_reg, alarmPick_reg;
  function automatic logic pickNext(input logic held, input logic [PF_W-1:0] pf,
                                    input logic [PF_W-1:0] thr);
    logic [15:0] scaled;
    scaled = 16'(pf) * 16'(RATIO_SCALE);
    if (held) pickNext = scaled < 16'(thr) * 16'(RESET_RATIO_PCT);
    else pickNext = pf < thr;
  endfunction
  always_ff @(posedge clock) begin
    if (rst) begin
      tripPick_reg <= 1'b0;
      alarmPick_reg <= 1'b0;
    end else if (hTick_reg) begin
      tripPick_reg <= pickNext(tripPick_reg, pfNow_reg, tripThreshold);
      alarmPick_reg <= alarmModeEn && pickNext(alarmPick_reg, pfNow_reg, alarmThreshold);
    end
  end

  // Two definite-time paths; decisions two cycles after sampling
  logic pTick_reg;
  always_ff @(posedge clock) begin
    if (rst) pTick_reg <= 1'b0;
    else pTick_reg <= hTick_reg;
  end
  logic tStart, tOp, tBlk, aStart, aOp, aBlk;
  logic [TIME_W-1:0] tRem, aRem;
  definite_time_path u_trip (
    .clock(clock), .rst(rst), .tick(pTick_reg), .enable(1'b1),
    .pickup(tripPick_reg), .blockIn(blkSample_reg), .delayTicks(tripDelay),
    .startOut(tStart), .operateOut(tOp), .blockedOut(tBlk), .remaining(tRem)
  );
  definite_time_path u_alarm (
    .clock(clock), .rst(rst), .tick(pTick_reg), .enable(alarmModeEn),
    .pickup(alarmPick_reg), .blockIn(blkSample_reg), .delayTicks(alarmDelay),
    .startOut(aStart), .operateOut(aOp), .blockedOut(aBlk), .remaining(aRem)
  );

  // Status flags with forcing
  logic [NUM_EVENTS-1:0] flags, flagsPrev_reg;
  stage_status_t statusNext;
  always_comb begin
    flags = '0;
    statusNext = ST_NORMAL;
    if (forceEnable) begin
      statusNext = forceStatus;
      case (forceStatus)
        ST_BLOCKED: flags[EV_BLOCK] = 1'b1;
        ST_START: flags[EV_START] = 1'b1;
        ST_TRIP: flags[EV_TRIP] = 1'b1;
        ST_ALARM_START: flags[EV_ALARM_START] = 1'b1;
        ST_ALARM: flags[EV_ALARM] = 1'b1;
        default: flags = '0;
      endcase
    end else begin
      flags[EV_BLOCK] = tBlk | aBlk;
      flags[EV_START] = tStart;
      flags[EV_TRIP] = tOp;
      flags[EV_ALARM_START] = aStart;
      flags[EV_ALARM] = aOp;
      if (tOp) statusNext = ST_TRIP;
      else if (tStart) statusNext = ST_START;
      else if (aOp) statusNext = ST_ALARM;
      else if (aStart) statusNext = ST_ALARM_START;
      else if (tBlk | aBlk) statusNext = ST_BLOCKED;
    end
  end

  logic [NUM_EVENTS-1:0] rising, falling;
  assign rising = flags & ~flagsPrev_reg;
  assign falling = ~flags & flagsPrev_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      flagsPrev_reg <= '0;
      status <= ST_NORMAL;
      eventOn <= '0;
      eventOff <= '0;
      eventTime <= '0;
    end else begin
      flagsPrev_reg <= flags;
      status <= statusNext;
      eventOn <= rising & onMask;
      eventOff <= falling & offMask;
      if ((rising | falling) != '0) eventTime <= timeStamp;
    end
  end

  // Counters; an occurrence in the clear cycle still counts
  always_ff @(posedge clock) begin
    if (rst) begin
      cntAlarmStart <= '0;
      cntAlarm <= '0;
      cntStart <= '0;
      cntTrip <= '0;
      cntBlocked <= '0;
    end else begin
      cntAlarmStart <= (counterClear ? '0 : cntAlarmStart) + CNT_W'(rising[EV_ALARM_START]);
      cntAlarm <= (counterClear ? '0 : cntAlarm) + CNT_W'(rising[EV_ALARM]);
      cntStart <= (counterClear ? '0 : cntStart) + CNT_W'(rising[EV_START]);
      cntTrip <= (counterClear ? '0 : cntTrip) + CNT_W'(rising[EV_TRIP]);
      cntBlocked <= (counterClear ? '0 : cntBlocked) + CNT_W'(rising[EV_BLOCK]);
    end
  end

  // Fault record ring of twelve
  logic [REC_W-1:0] rec_reg [REC_DEPTH];
  logic [REC_IDX_W-1:0] wrIdx_reg;
  logic recWrite;
  event_id_t recEvent;
  assign recWrite = rising[EV_START] | rising[EV_TRIP] | rising[EV_BLOCK];
  assign recEvent = rising[EV_TRIP] ? EV_TRIP : (rising[EV_START] ? EV_START : EV_BLOCK);
  always_ff @(posedge clock) begin
    if (rst) wrIdx_reg <= '0;
    else if (recWrite) begin
      wrIdx_reg <= (wrIdx_reg == REC_IDX_W'(REC_DEPTH - 1)) ? '0 : wrIdx_reg + REC_IDX_W'(1);
    end
  end
  generate
    for (gi = 0; gi < REC_DEPTH; gi++) begin : g_rec
      always_ff @(posedge clock) begin
        if (rst) rec_reg[gi] <= '0;
        else if (recWrite && wrIdx_reg == REC_IDX_W'(gi)) begin
          rec_reg[gi] <= {timeStamp, recEvent, hist_reg[PRE_TRIG_TICKS], pfNow_reg,
                          hist_reg[PRE_FAULT_TICKS], tRem, settingGroup};
        end
      end
    end
  endgenerate

  // Read-only views
  logic [15:0] ratioNext;
  assign ratioNext = (tripThreshold == '0) ? '0 :
                     16'((16'(pfNow_reg) * 16'(RATIO_SCALE)) / 16'(tripThreshold));
  always_ff @(posedge clock) begin
    if (rst) begin
      alarmRemaining <= '0;
      alarmExpected <= '0;
      tripRemaining <= '0;
      ratioToTrip <= '0;
      recData <= '0;
    end else begin
      alarmRemaining <= aRem;
      alarmExpected <= alarmModeEn ? alarmDelay : '0;
      tripRemaining <= tRem;
      ratioToTrip <= ratioNext;
      recData <= (recReadIdx < REC_IDX_W'(REC_DEPTH)) ?
                 rec_reg[recReadIdx] : '0;
    end
  end

  property p_tick_period;
    @(posedge clock) disable iff (rst) tick |=> !tick[*1];
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Tick not a single pulse");
  property p_alarm_needs_mode;
    @(posedge clock) disable iff (rst) (!alarmModeEn && pTick_reg) |=> !aOp;
  endproperty
  a_alarm_needs_mode: assert property (p_alarm_needs_mode)
    else $error("Alarm while alarm mode off");
  property p_pick_below;
    @(posedge clock) disable iff (rst)
      (hTick_reg && !tripPick_reg && pfNow_reg < tripThreshold) |=> tripPick_reg;
  endproperty
  a_pick_below: assert property (p_pick_below)
    else $error("Missed pick-up below threshold");
  property p_hold_hyst;
    @(posedge clock) disable iff (rst)
      (hTick_reg && tripPick_reg && 16'(pfNow_reg) * 16'h64 < 16'(tripThreshold) * 16'h67)
      |=> tripPick_reg;
  endproperty
  a_hold_hyst: assert property (p_hold_hyst)
    else $error("Released inside hysteresis");
  property p_force;
    @(posedge clock) disable iff (rst) forceEnable |=> status == $past(forceStatus);
  endproperty
  a_force: assert property (p_force)
    else $error("Forced status not shown");
  property p_on_event;
    @(posedge clock) disable iff (rst)
      (rising[EV_TRIP] && onMask[EV_TRIP]) |=> eventOn[EV_TRIP];
  endproperty
  a_on_event: assert property (p_on_event)
    else $error("Trip ON event missing");
  property p_count;
    @(posedge clock) disable iff (rst)
      (rising[EV_START] && !counterClear) |=> cntStart == $past(cntStart) + 16'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("Start counter did not advance");
  property p_rec_wrap;
    @(posedge clock) disable iff (rst) wrIdx_reg < 4'hC;
  endproperty
  a_rec_wrap: assert property (p_rec_wrap)
    else $error("Record index out of range");
  c_trip: cover property (@(posedge clock) disable iff (rst) $rose(tOp));
  c_blocked: cover property (@(posedge clock) disable iff (rst) $rose(tBlk));
  c_alarm: cover property (@(posedge clock) disable iff (rst) $rose(aOp));
endmodule
